// ===== rtl/osl_pkg.sv
// constants, register map and helpers for the output size limiter path
package osl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int PIX_W = 10;
    localparam int FIFO_DEPTH = 2064;

    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_X_ODD_INC = 4'h1;
    localparam logic [3:0] OFS_Y_ODD_INC = 4'h2;
    localparam logic [3:0] OFS_X_OUT_SIZE = 4'h3;
    localparam logic [3:0] OFS_Y_OUT_SIZE = 4'h4;
    localparam logic [3:0] OFS_LINE_LEN = 4'h5;
    localparam logic [3:0] OFS_FRAME_LEN = 4'h6;
    localparam logic [3:0] OFS_CORE_W = 4'h7;
    localparam logic [3:0] OFS_CORE_H = 4'h8;
    localparam logic [3:0] OFS_LINK_RATE = 4'h9;
    localparam logic [3:0] OFS_STATUS = 4'ha;

    // control fields
    localparam int CTRL_SERIAL_BIT = 0;
    localparam int CTRL_SCALER_BIT = 1;
    localparam int CTRL_CLASS2_BIT = 2;
    localparam int CTRL_FMT_LSB = 8;
    // status fields
    localparam int ST_XSKIP_LSB = 0;
    localparam int ST_YSKIP_LSB = 3;
    localparam int ST_UNDERRUN_BIT = 8;
    localparam int ST_OVERRUN_BIT = 9;
    localparam int ST_STALL_BIT = 10;
    localparam int ST_RATE_ERR_BIT = 11;
    localparam int ST_SIZE_ERR_BIT = 12;

    localparam logic [15:0] RST_CTRL = 16'h0a05;
    localparam logic [15:0] RST_ODD_INC = 16'h0001;
    localparam logic [15:0] RST_X_OUT_SIZE = 16'h0800;
    localparam logic [15:0] RST_Y_OUT_SIZE = 16'h0602;
    localparam logic [15:0] RST_LINE_LEN = 16'h0a3e;
    localparam logic [15:0] RST_FRAME_LEN = 16'h0655;
    localparam logic [15:0] RST_CORE_W = 16'h0800;
    localparam logic [15:0] RST_CORE_H = 16'h0602;
    localparam logic [15:0] RST_LINK_RATE = 16'h0000;

    localparam logic [7:0] FMT_RAW8 = 8'h08;
    localparam logic [7:0] FMT_RAW10 = 8'h0a;
    localparam logic [15:0] X_OUT_MIN = 16'h0100;
    localparam logic [15:0] X_OUT_MAX = 16'h0810;
    localparam logic [15:0] Y_OUT_MIN = 16'h0002;
    localparam logic [15:0] RATE_MAX_CLASS0 = 16'h00d0;
    localparam logic [15:0] RATE_MAX_CLASS2 = 16'h028a;
    localparam logic [15:0] EVEN_MASK = 16'hfffe;
    localparam logic [15:0] RND4_ADD = 16'h0003;
    localparam logic [15:0] RND4_MASK = 16'hfffc;
    localparam logic [15:0] RND16_ADD = 16'h000f;
    localparam logic [15:0] RND16_MASK = 16'hfff0;
    // mid-scale pad value, far from the all-ones/all-zeros sync codes
    localparam logic [PIX_W-1:0] PAD_PIX = 10'h200;

    localparam logic [15:0] ODD_INC_NONE = 16'h0001;
    localparam logic [15:0] ODD_INC_HALF = 16'h0003;
    localparam logic [2:0] SKIP_1 = 3'h1;
    localparam logic [2:0] SKIP_2 = 3'h2;
    localparam logic [2:0] SKIP_4 = 3'h4;

    function automatic logic [2:0] osl_skip_factor(input logic [15:0] odd_inc);
        logic [2:0] f;
        f = SKIP_4;
        if (odd_inc == ODD_INC_NONE)
        begin
            f = SKIP_1;
        end
        else if (odd_inc == ODD_INC_HALF)
        begin
            f = SKIP_2;
        end
        return f;
    endfunction
endpackage

// ===== rtl/osl_pix_if.sv
// pixel stream carrier between limiter and output fifo
`timescale 1ns/10ps
`default_nettype none
interface osl_pix_if;
    logic line_valid;
    logic pix_valid;
    logic line_end;
    logic [osl_pkg::PIX_W-1:0] pix;
    modport src(output line_valid, output pix_valid, output line_end,
        output pix);
    modport snk(input line_valid, input pix_valid, input line_end,
        input pix);
endinterface
`default_nettype wire

// ===== rtl/osl_limiter.sv
// row limiter: passes scaler pixels, clips or pads each row to a width
`timescale 1ns/10ps
`default_nettype none
module osl_limiter (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic line_in,
    input wire logic valid_in,
    input wire logic [osl_pkg::PIX_W-1:0] pix_in,
    input wire logic [15:0] width,
    output logic padding,
    osl_pix_if.src out
);
    import osl_pkg::*;

    typedef enum logic [1:0] {LIM_WAIT, LIM_ROW, LIM_PAD} osl_lim_st_type;
    typedef struct packed {
        osl_lim_st_type st;
        logic [15:0] cnt;
        logic line_valid;
        logic pix_valid;
        logic line_end;
        logic [PIX_W-1:0] pix;
    } osl_lim_state_type;

    osl_lim_state_type state_reg;
    osl_lim_state_type state_next;

    always_comb
    begin
        state_next = state_reg;
        state_next.pix_valid = 1'b0;
        state_next.line_end = 1'b0;
        case (state_reg.st)
            LIM_WAIT:
            begin
                state_next.line_valid = line_in;
                state_next.cnt = 16'h0000;
                if (line_in)
                begin
                    state_next.st = LIM_ROW;
                end
            end
            LIM_ROW, LIM_PAD:
            begin
            end
            default:
            begin
                state_next.st = LIM_WAIT;
            end
        endcase
        if (state_next.st == LIM_ROW)
        begin
            if (line_in && valid_in && state_next.cnt < width)
            begin
                state_next.pix_valid = 1'b1;
                state_next.pix = pix_in;
                state_next.cnt = state_next.cnt + 16'h0001;
                state_next.line_end = (state_next.cnt == width);
            end
            else if (!line_in)
            begin
                // pixels beyond the width were dropped; short rows get padded
                if (state_next.cnt < width)
                begin
                    state_next.st = LIM_PAD;
                end
                else
                begin
                    state_next.st = LIM_WAIT;
                end
            end
        end
        else if (state_next.st == LIM_PAD)
        begin
            state_next.pix_valid = 1'b1;
            state_next.pix = PAD_PIX;
            state_next.cnt = state_next.cnt + 16'h0001;
            state_next.line_end = (state_next.cnt == width);
            if (state_next.line_end)
            begin
                state_next.st = LIM_WAIT;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_reg <= '{st: LIM_WAIT, cnt: 16'h0000, line_valid: 1'b0,
                pix_valid: 1'b0, line_end: 1'b0, pix: '0};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign padding = (state_reg.st == LIM_PAD);
    assign out.line_valid = state_reg.line_valid;
    assign out.pix_valid = state_reg.pix_valid;
    assign out.line_end = state_reg.line_end;
    assign out.pix = state_reg.pix;
endmodule
`default_nettype wire

// ===== rtl/osl_fifo.sv
// output fifo: stores pixel plus end-of-row mark, registered read port
`timescale 1ns/10ps
`default_nettype none
module osl_fifo #(
    parameter int DEPTH = osl_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    osl_pix_if.snk wr,
    input wire logic rd_en,
    output logic [osl_pkg::PIX_W:0] rd_data,
    output logic empty,
    output logic full
);
    import osl_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [PIX_W:0] q;
    } osl_fifo_state_type;

    osl_fifo_state_type state_reg;
    osl_fifo_state_type state_next;
    logic [PIX_W:0] mem [DEPTH];
    logic wr_ok;
    logic rd_ok;

    assign empty = (state_reg.cnt == '0);
    assign full = (state_reg.cnt == FULL_CNT);
    assign wr_ok = wr.pix_valid && !full;
    assign rd_ok = rd_en && !empty;

    always_comb
    begin
        state_next = state_reg;
        if (wr_ok)
        begin
            state_next.wp = (state_reg.wp == LAST_IDX) ? '0
                : state_reg.wp + 1'b1;
        end
        if (rd_ok)
        begin
            state_next.q = mem[state_reg.rp];
            state_next.rp = (state_reg.rp == LAST_IDX) ? '0
                : state_reg.rp + 1'b1;
        end
        if (wr_ok && !rd_ok)
        begin
            state_next.cnt = state_reg.cnt + 1'b1;
        end
        else if (rd_ok && !wr_ok)
        begin
            state_next.cnt = state_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (wr_ok)
        begin
            mem[state_reg.wp] <= {wr.line_end, wr.pix};
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign rd_data = state_reg.q;
endmodule
`default_nettype wire

// ===== rtl/osl_top.sv
// output sizing path: timing, scaler, limiter, output fifo and registers
//
// How it works
// - skip factor 1, 2 or 4 from odd step
// - width and count bit 0 reads zero
// - serial rows rounded to 32-bit multiples
// - pad pixels never mimic sync codes
// - core row flag per row, all valid
// - scaler marks surviving pixels, same row time
// - limiter pads short rows to width
// - padding across blanking stops frames
// - fifo rejoins pixels into contiguous rows
// - fifo read on clk, paced by synced op_clk edges
// - frame period is row period times rows
// - full frame 1536 rows plus 2 embedded
// - default 10-bit pixels, 8-bit selectable
// - faster class link at most 650 Mb/s
// - data-clock class at most 208 Mb/s
// - fifo single-clock; op_clk sampled into clk
// - fifo underrun or overrun flagged fatal
`timescale 1ns/10ps
`default_nettype none
module osl_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [osl_pkg::ADDR_W-1:0] addr,
    input wire logic [osl_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [osl_pkg::DATA_W-1:0] rdata,
    input wire logic [osl_pkg::PIX_W-1:0] array_pix,
    input wire logic op_clk,
    output logic out_frame_valid,
    output logic out_line_valid,
    output logic out_pix_valid,
    output logic [osl_pkg::PIX_W-1:0] out_pix
);
    import osl_pkg::*;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] x_odd;
        logic [15:0] y_odd;
        logic [15:0] x_out;
        logic [15:0] y_out;
        logic [15:0] line_len;
        logic [15:0] frame_len;
        logic [15:0] core_w;
        logic [15:0] core_h;
        logic [15:0] rate;
        logic underrun;
        logic overrun;
        logic stalled;
        logic [15:0] rdata;
        logic [15:0] h;
        logic [15:0] v;
        logic core_line_d;
        logic [PIX_W-1:0] held;
        logic sc_line;
        logic sc_valid;
        logic [PIX_W-1:0] sc_pix;
        logic op_s1;
        logic op_s2;
        logic op_s3;
        logic popped;
        logic in_row;
        logic last_out;
        logic line_valid;
        logic pix_valid;
        logic [PIX_W-1:0] pix;
        logic frame_valid;
    } osl_top_state_type;

    osl_top_state_type state_reg;
    osl_top_state_type state_next;

    osl_pix_if lim_if ();

    logic padding;
    logic [PIX_W:0] fifo_q;
    logic fifo_empty;
    logic fifo_full;
    logic fifo_pop;
    logic [15:0] target_w;
    logic [7:0] fmt;
    logic serial_en;
    logic core_line;
    logic core_frame;
    logic op_edge;
    logic [PIX_W:0] pair_sum;
    logic [2:0] xskip;
    logic [2:0] yskip;
    logic rate_err;
    logic size_err;
    logic [15:0] status;
    logic clr_under;
    logic clr_over;
    logic clr_stall;

    assign fmt = state_reg.ctrl[CTRL_FMT_LSB +: 8];
    assign serial_en = state_reg.ctrl[CTRL_SERIAL_BIT];
    assign xskip = osl_skip_factor(state_reg.x_odd);
    assign yskip = osl_skip_factor(state_reg.y_odd);

    // width sent to the limiter, rounded up to whole 32-bit serial words in serial mode
    always_comb
    begin
        target_w = state_reg.x_out;
        if (serial_en && fmt == FMT_RAW8)
        begin
            target_w = (state_reg.x_out + RND4_ADD) & RND4_MASK;
        end
        else if (serial_en && fmt == FMT_RAW10)
        begin
            target_w = (state_reg.x_out + RND16_ADD) & RND16_MASK;
        end
    end

    // core rows and frames within the blanked frame period
    assign core_line = (state_reg.h < state_reg.core_w)
        && (state_reg.v < state_reg.core_h);
    assign core_frame = (state_reg.v < state_reg.core_h);
    assign pair_sum = {1'b0, state_reg.held} + {1'b0, array_pix};

    // only flags the host's limits; a bad setting is not blocked here
    assign rate_err = state_reg.rate > (state_reg.ctrl[CTRL_CLASS2_BIT]
        ? RATE_MAX_CLASS2 : RATE_MAX_CLASS0);
    assign size_err = (state_reg.x_out < X_OUT_MIN)
        || (state_reg.x_out > X_OUT_MAX)
        || (state_reg.y_out < Y_OUT_MIN)
        || (state_reg.y_out > state_reg.frame_len)
        || (serial_en && fmt == FMT_RAW8 && state_reg.x_out[1:0] != 2'h0)
        || (serial_en && fmt == FMT_RAW10
        && state_reg.x_out[3:0] != 4'h0);

    always_comb
    begin
        status = 16'h0000;
        status[ST_XSKIP_LSB +: 3] = xskip;
        status[ST_YSKIP_LSB +: 3] = yskip;
        status[ST_UNDERRUN_BIT] = state_reg.underrun;
        status[ST_OVERRUN_BIT] = state_reg.overrun;
        status[ST_STALL_BIT] = state_reg.stalled;
        status[ST_RATE_ERR_BIT] = rate_err;
        status[ST_SIZE_ERR_BIT] = size_err;
    end

    assign clr_under = wr && addr == OFS_STATUS && wdata[ST_UNDERRUN_BIT];
    assign clr_over = wr && addr == OFS_STATUS && wdata[ST_OVERRUN_BIT];
    assign clr_stall = wr && addr == OFS_STATUS && wdata[ST_STALL_BIT];

    // op_s1 feeds only op_s2; the edge is taken between s2 and s3
    assign op_edge = state_reg.op_s2 && !state_reg.op_s3;
    assign fifo_pop = op_edge && !state_reg.last_out && !fifo_empty;

    always_comb
    begin
        state_next = state_reg;
        state_next.rdata = 16'h0000;
        if (wr)
        begin
            case (addr)
                OFS_CTRL: state_next.ctrl = wdata;
                OFS_X_ODD_INC: state_next.x_odd = wdata;
                OFS_Y_ODD_INC: state_next.y_odd = wdata;
                OFS_X_OUT_SIZE: state_next.x_out = wdata & EVEN_MASK;
                OFS_Y_OUT_SIZE: state_next.y_out = wdata & EVEN_MASK;
                OFS_LINE_LEN: state_next.line_len = wdata;
                OFS_FRAME_LEN: state_next.frame_len = wdata;
                OFS_CORE_W: state_next.core_w = wdata;
                OFS_CORE_H: state_next.core_h = wdata;
                OFS_LINK_RATE: state_next.rate = wdata;
                default:
                begin
                end
            endcase
        end
        if (rd)
        begin
            case (addr)
                OFS_CTRL: state_next.rdata = state_reg.ctrl;
                OFS_X_ODD_INC: state_next.rdata = state_reg.x_odd;
                OFS_Y_ODD_INC: state_next.rdata = state_reg.y_odd;
                OFS_X_OUT_SIZE: state_next.rdata = state_reg.x_out;
                OFS_Y_OUT_SIZE: state_next.rdata = state_reg.y_out;
                OFS_LINE_LEN: state_next.rdata = state_reg.line_len;
                OFS_FRAME_LEN: state_next.rdata = state_reg.frame_len;
                OFS_CORE_W: state_next.rdata = state_reg.core_w;
                OFS_CORE_H: state_next.rdata = state_reg.core_h;
                OFS_LINK_RATE: state_next.rdata = state_reg.rate;
                OFS_STATUS: state_next.rdata = status;
                default: state_next.rdata = 16'h0000;
            endcase
        end

        // array readout: line_len pixels per row, frame_len rows per frame
        if (state_reg.h + 16'h0001 >= state_reg.line_len)
        begin
            state_next.h = 16'h0000;
            if (state_reg.v + 16'h0001 >= state_reg.frame_len)
            begin
                state_next.v = 16'h0000;
            end
            else
            begin
                state_next.v = state_reg.v + 16'h0001;
            end
        end
        else
        begin
            state_next.h = state_reg.h + 16'h0001;
        end

        // half-size scaler averages pixel pairs, row time unchanged
        state_next.core_line_d = core_line;
        state_next.sc_line = core_line && !state_reg.stalled;
        state_next.sc_valid = 1'b0;
        if (core_line)
        begin
            state_next.held = array_pix;
            if (!state_reg.ctrl[CTRL_SCALER_BIT])
            begin
                state_next.sc_valid = !state_reg.stalled;
                state_next.sc_pix = array_pix;
            end
            else if (state_reg.h[0])
            begin
                state_next.sc_valid = !state_reg.stalled;
                state_next.sc_pix = pair_sum[PIX_W:1];
            end
        end

        // padding still running at the next row start: stop frames
        state_next.stalled = (state_reg.stalled && !clr_stall)
            || (padding && core_line && !state_reg.core_line_d);

        state_next.overrun = (state_reg.overrun && !clr_over)
            || (lim_if.pix_valid && fifo_full);

        // read side, one pixel per output clock edge
        state_next.op_s1 = op_clk;
        state_next.op_s2 = state_reg.op_s1;
        state_next.op_s3 = state_reg.op_s2;
        state_next.popped = fifo_pop;
        state_next.underrun = state_reg.underrun && !clr_under;
        if (state_reg.popped)
        begin
            state_next.pix = fifo_q[PIX_W-1:0];
            state_next.pix_valid = 1'b1;
            state_next.line_valid = 1'b1;
            state_next.in_row = !fifo_q[PIX_W];
            state_next.last_out = fifo_q[PIX_W];
        end
        else if (op_edge && !fifo_pop)
        begin
            // a gap of one output period follows every row end
            if (state_reg.in_row)
            begin
                state_next.underrun = 1'b1;
            end
            state_next.in_row = 1'b0;
            state_next.last_out = 1'b0;
            state_next.line_valid = 1'b0;
            state_next.pix_valid = 1'b0;
        end
        state_next.frame_valid = (core_frame && !state_reg.stalled)
            || !fifo_empty || state_reg.line_valid;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_reg <= '0;
            state_reg.ctrl <= RST_CTRL;
            state_reg.x_odd <= RST_ODD_INC;
            state_reg.y_odd <= RST_ODD_INC;
            state_reg.x_out <= RST_X_OUT_SIZE;
            state_reg.y_out <= RST_Y_OUT_SIZE;
            state_reg.line_len <= RST_LINE_LEN;
            state_reg.frame_len <= RST_FRAME_LEN;
            state_reg.core_w <= RST_CORE_W;
            state_reg.core_h <= RST_CORE_H;
            state_reg.rate <= RST_LINK_RATE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    osl_limiter u_limiter (
        .clk(clk),
        .reset_n(reset_n),
        .line_in(state_reg.sc_line),
        .valid_in(state_reg.sc_valid),
        .pix_in(state_reg.sc_pix),
        .width(target_w),
        .padding(padding),
        .out(lim_if.src)
    );

    // written from the video timing domain, drained at output edges
    osl_fifo #(
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .wr(lim_if.snk),
        .rd_en(fifo_pop),
        .rd_data(fifo_q),
        .empty(fifo_empty),
        .full(fifo_full)
    );

    assign rdata = state_reg.rdata;
    assign out_frame_valid = state_reg.frame_valid;
    assign out_line_valid = state_reg.line_valid;
    assign out_pix_valid = state_reg.pix_valid;
    assign out_pix = state_reg.pix;
endmodule
`default_nettype wire

// ===== tb/osl_top_monitor.sv
// assertion checker and bind for the output size limiter path
`timescale 1ns/10ps
`default_nettype none
module osl_top_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [osl_pkg::ADDR_W-1:0] addr,
    input wire logic [osl_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [osl_pkg::DATA_W-1:0] rdata,
    input wire logic [osl_pkg::PIX_W-1:0] array_pix,
    input wire logic op_clk,
    input wire logic out_frame_valid,
    input wire logic out_line_valid,
    input wire logic out_pix_valid,
    input wire logic [osl_pkg::PIX_W-1:0] out_pix
);
    import osl_pkg::*;
    logic [15:0] xi_reg;
    logic [5:0] op_reg;
    logic op_rise;
    logic [2:0] xs_exp;
    // row flag falls 3 clk and pixels move 4 clk after an op rise; 3-wide window absorbs sampling
    assign op_rise = |(op_reg[4:2] & ~op_reg[5:3]);
    assign xs_exp = (xi_reg == 16'h0001) ? 3'h1 :
        (xi_reg == 16'h0003) ? 3'h2 : 3'h4;
    always_ff @(posedge clk)
    begin
        op_reg <= {op_reg[4:0], op_clk};
        if (!reset_n)
            xi_reg <= RST_ODD_INC;
        else if (wr && addr == OFS_X_ODD_INC)
            xi_reg <= wdata;
    end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_xskip_read: assert property (
        rd && addr == OFS_STATUS |=> rdata[2:0] == xs_exp)
        else $error("x skip field wrong");
    a_width_even: assert property (
        rd && addr == OFS_X_OUT_SIZE |=> !rdata[0])
        else $error("width bit 0 set");
    a_count_even: assert property (
        rd && addr == OFS_Y_OUT_SIZE |=> !rdata[0])
        else $error("count bit 0 set");
    a_pix_qual: assert property (out_pix_valid == out_line_valid)
        else $error("pixel qualifier off row flag");
    a_line_frame: assert property (out_line_valid |-> out_frame_valid)
        else $error("row outside frame");
    a_row_gap: assert property (
        $fell(out_line_valid) |=> !out_line_valid [*6])
        else $error("row gap too short");
    a_op_align: assert property ($changed(out_line_valid) |-> op_rise)
        else $error("row flag off op edge");
    a_pix_hold: assert property ($changed(out_pix) |-> op_rise)
        else $error("pixel off op edge");
    c_row: cover property ($rose(out_line_valid));
    c_gap: cover property ($fell(out_line_valid));
    c_stat: cover property (rd && addr == OFS_STATUS);
endmodule
bind osl_top osl_top_monitor mon_u (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .array_pix(array_pix),
    .op_clk(op_clk), .out_frame_valid(out_frame_valid),
    .out_line_valid(out_line_valid), .out_pix_valid(out_pix_valid),
    .out_pix(out_pix));
`default_nettype wire

// ===== tb/osl_rx_model.sv
// receiver model: makes the output clock and measures each row
`timescale 1ns/10ps
`default_nettype none
module osl_rx_model (
    output logic op_clk,
    input wire logic line_valid,
    input wire logic [osl_pkg::PIX_W-1:0] pix,
    output int row_len,
    output logic [osl_pkg::PIX_W-1:0] last_pix
);
    import osl_pkg::*;
    int cnt = 0;
    // edges at 32 ns steps never meet a system clock rise
    initial op_clk = 1'b0;
    always #32 op_clk = ~op_clk;
    always @(posedge op_clk)
    begin
        if (line_valid)
        begin
            cnt <= cnt + 1;
            last_pix <= pix;
        end
        else if (cnt != 0)
        begin
            row_len <= cnt;
            cnt <= 0;
        end
    end
endmodule
`default_nettype wire

// ===== tb/osl_top_tb.sv
// self-checking bench for the output size limiter path
`timescale 1ns/10ps
`default_nettype none
module osl_top_tb;
    import osl_pkg::*;
    logic clk, reset_n, wr, rd, op_clk;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, rv;
    logic [PIX_W-1:0] array_pix, out_pix, last_pix;
    logic out_frame_valid, out_line_valid, out_pix_valid;
    int error_cnt = 0;
    int checked = 0;
    int row_len;
    // ctrl, width, count, expected size error
    logic [63:0] sz_tab [10] = '{
        64'h0a05_0100_0002_0000, 64'h0a05_00f0_0002_1000,
        64'h0a05_0810_0002_0000, 64'h0a05_0820_0002_1000,
        64'h0a05_0100_0000_1000, 64'h0a05_0100_0656_1000,
        64'h0805_0104_0002_0000, 64'h0805_0106_0002_1000,
        64'h0a05_0104_0002_1000, 64'h0a04_0106_0002_0000};
    // ctrl, link rate, expected rate error
    logic [47:0] rt_tab [4] = '{48'h0a05_028a_0000, 48'h0a05_028b_0800,
        48'h0a01_00d0_0000, 48'h0a01_00d1_0800};
    logic [15:0] odd_tab [4] = '{16'h1, 16'h3, 16'h5, 16'h7};
    logic [2:0] skip_tab [4] = '{3'h1, 3'h2, 3'h4, 3'h4};
    osl_top dut_u (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .array_pix(array_pix),
        .op_clk(op_clk), .out_frame_valid(out_frame_valid),
        .out_line_valid(out_line_valid), .out_pix_valid(out_pix_valid),
        .out_pix(out_pix));
    osl_rx_model rx_u (.op_clk(op_clk), .line_valid(out_line_valid),
        .pix(out_pix), .row_len(row_len), .last_pix(last_pix));
    always #4 clk = ~clk;
    task automatic stop_test;
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] s, e);
        checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [15:0] m, e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), rdata & m, e);
    endtask
    // settle, clear stale flags, then let several frames pass
    task automatic pix_case(input logic [15:0] c, x, n, p);
        wr_reg(OFS_CTRL, c);
        wr_reg(OFS_X_OUT_SIZE, x);
        repeat (600) @(posedge clk);
        wr_reg(OFS_STATUS, 16'h0700);
        repeat (6000) @(posedge clk);
        chk("row length", 16'(row_len), n);
        chk("last pixel", {6'h0, last_pix}, p);
    endtask
    initial
    begin
        clk = 1'b0;
        reset_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        array_pix = 10'h155;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rchk(OFS_LINE_LEN, 16'hffff, 16'd2622);
        rchk(OFS_FRAME_LEN, 16'hffff, 16'd1621);
        rchk(OFS_Y_OUT_SIZE, 16'hffff, 16'd1538);
        rchk(OFS_CTRL, 16'hff00, 16'h0a00);
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(OFS_X_ODD_INC, odd_tab[i]);
            wr_reg(OFS_Y_ODD_INC, odd_tab[3 - i]);
            rv = {10'h0, skip_tab[3 - i], skip_tab[i]};
            rchk(OFS_STATUS, 16'h003f, rv);
        end
        wr_reg(OFS_X_OUT_SIZE, 16'h0401);
        rchk(OFS_X_OUT_SIZE, 16'hffff, 16'h0400);
        wr_reg(OFS_Y_OUT_SIZE, 16'h0003);
        rchk(OFS_Y_OUT_SIZE, 16'hffff, 16'h0002);
        wr_reg(4'hb, 16'hffff);
        rchk(4'hb, 16'hffff, 16'h0000);
        foreach (sz_tab[i])
        begin
            wr_reg(OFS_CTRL, sz_tab[i][63:48]);
            wr_reg(OFS_X_OUT_SIZE, sz_tab[i][47:32]);
            wr_reg(OFS_Y_OUT_SIZE, sz_tab[i][31:16]);
            rchk(OFS_STATUS, 16'h1000, sz_tab[i][15:0]);
        end
        foreach (rt_tab[i])
        begin
            wr_reg(OFS_CTRL, rt_tab[i][47:32]);
            wr_reg(OFS_LINK_RATE, rt_tab[i][31:16]);
            rchk(OFS_STATUS, 16'h0800, rt_tab[i][15:0]);
        end
        // shrink width before the row so no padding spans the short row
        wr_reg(OFS_X_OUT_SIZE, 16'h0008);
        wr_reg(OFS_CORE_W, 16'h0010);
        wr_reg(OFS_CORE_H, 16'h0004);
        wr_reg(OFS_LINE_LEN, 16'h0100);
        wr_reg(OFS_FRAME_LEN, 16'h0008);
        pix_case(16'h0a04, 16'h0008, 16'd8, 16'h0155);
        pix_case(16'h0a06, 16'h0010, 16'd16, {6'h0, PAD_PIX});
        pix_case(16'h0807, 16'h000a, 16'd12, {6'h0, PAD_PIX});
        pix_case(16'h0a07, 16'h000a, 16'd16, {6'h0, PAD_PIX});
        wr_reg(OFS_CTRL, 16'h0a06);
        wr_reg(OFS_X_OUT_SIZE, 16'h0810);
        repeat (1000) @(posedge clk);
        rchk(OFS_STATUS, 16'h0400, 16'h0400);
        // let the long pad finish before shrinking the width
        repeat (2600) @(posedge clk);
        wr_reg(OFS_CTRL, 16'h0a04);
        wr_reg(OFS_X_OUT_SIZE, 16'h00f0);
        wr_reg(OFS_CORE_W, 16'h00f0);
        wr_reg(OFS_CORE_H, 16'h0008);
        wr_reg(OFS_STATUS, 16'h0700);
        repeat (3000) @(posedge clk);
        rchk(OFS_STATUS, 16'h0200, 16'h0200);
        stop_test;
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        stop_test;
    end
endmodule
`default_nettype wire
